// [rtl/gcid_pkg.sv]
// Constants for the global command and identification register block
package gcid_pkg;
	// ----------------------------------------
	// Register byte addresses (lower byte of each word, except ADDR_CMD_HI)
	// ----------------------------------------
	localparam logic [6:0] ADDR_CMD_LO = 7'h68;
	localparam logic [6:0] ADDR_CMD_HI = 7'h69;
	localparam logic [6:0] ADDR_FW_REV = 7'h6C;
	localparam logic [6:0] ADDR_MONTH_DAY = 7'h6E;
	localparam logic [6:0] ADDR_YEAR = 7'h70;
	localparam logic [6:0] ADDR_PRODUCT = 7'h72;
	localparam logic [6:0] ADDR_SERIAL = 7'h74;
	localparam logic [6:0] ADDR_SCRATCH1 = 7'h76;
	localparam logic [6:0] ADDR_SCRATCH2 = 7'h78;
	localparam logic [6:0] ADDR_SCRATCH3 = 7'h7A;
	localparam logic [6:0] ADDR_FLASH_LO = 7'h7C;
	localparam logic [6:0] ADDR_FLASH_HI = 7'h7E;
	// ----------------------------------------
	// Command bit positions
	// ----------------------------------------
	localparam int CMD_BIAS_UPD = 0;
	localparam int CMD_FACTORY = 1;
	localparam int CMD_SELFTEST = 2;
	localparam int CMD_BACKUP = 3;
	localparam int CMD_FLASHTEST = 4;
	localparam int CMD_SOFT_RESET = 7;
	// Diagnostic status bit positions
	localparam int DIAG_BACKUP_FAIL = 2;
	localparam int DIAG_SELFTEST_FAIL = 5;
	localparam int DIAG_FLASH_FAIL = 6;
	// ----------------------------------------
	// Frame layout
	// ----------------------------------------
	localparam int FRAME_BITS = 16;
	localparam int FRAME_WR_BIT = 15;
	// ----------------------------------------
	// Reset values and identity (identity values arbitrary)
	// ----------------------------------------
	localparam logic [15:0] SCRATCH_RST = 16'h0000;
	localparam logic [31:0] FLASH_CNT_RST = 32'h0000_0000;
	localparam logic [15:0] PRODUCT_CODE_VAL = 16'h1234; // Arbitrary value
	localparam logic [15:0] SERIAL_VAL = 16'h0001; // Arbitrary value
	localparam logic [15:0] FW_REV_VAL = 16'h0100;
	localparam logic [15:0] MONTH_DAY_VAL = 16'h0101;
	localparam logic [15:0] YEAR_VAL = 16'h2000;
	// ----------------------------------------
	// Command execution time
	// ----------------------------------------
	localparam int CMD_TIME_US = 20;
	localparam int CLK_MHZ = 100;
	localparam logic [15:0] CMD_CYCLES = 16'(CMD_TIME_US * CLK_MHZ);
	typedef enum logic [1:0] {GCID_IDLE, GCID_STIM_OFF, GCID_STIM_ON, GCID_RUN} gcid_state_t;
endpackage

// [rtl/gcid_top.sv]
// Global command interpreter with identification, scratch and flash-wear registers
// Notes on behaviour
// - Writing one to a command bit starts that function; zero starts nothing.
// - While a command runs, data, ready pulses and serial requests are suspended.
// - Bit 7 resets the device, clearing data, then sampling restarts.
// - Bit 4 computes flash CRC excluding user registers, compares with factory CRC.
// - CRC mismatch sets diagnostic bit 6.
// - Bit 3 copies user registers into flash as backup.
// - Backup outcome goes to diagnostic bit 2: zero pass, one fail.
// - Bit 2 launches the sensor self-test.
// - Self-test measures, stimulates, measures, removes stimulus, compares difference to limits.
// - Self-test result goes to diagnostic bit 5.
// - Bit 1 reloads factory defaults into control, decimation and filter registers.
// - Factory restore also zeroes all twelve bias correction words.
// - Bit 0 applies bias correction from the continuous estimator.
// - Firmware revision reads as 16-bit BCD.
// - Month-day register holds month BCD upper byte, day BCD lower byte.
// - Year register holds four-digit BCD year, read-only.
// - Product code register returns a fixed identification code.
// - Serial register returns a read-only lot serial number.
// - Three scratch words read and write freely without side effect.
// - A 32-bit flash write count, split low and high, increments each flash write.
`timescale 1ns/1ps
`default_nettype none
module gcid_top
(
	input wire logic SYS_CLK,
	input wire logic SRST,
	input wire logic SCLK,
	input wire logic CS_N,
	input wire logic DIN,
	output logic DOUT,
	input wire logic DATA_READY_IN,
	output logic DATA_READY_OUT,
	output logic DATA_HALT,
	output logic SENSOR_RESTART,
	output logic FACTORY_RESTORE,
	output logic BIAS_ZERO,
	output logic BIAS_APPLY,
	output logic FLASH_BACKUP,
	output logic STIMULUS_ON,
	output logic MEASURE_STROBE,
	input wire logic MEASURE_DONE,
	input wire logic SELFTEST_FAIL_IN,
	input wire logic CRC_MISMATCH_IN,
	input wire logic BACKUP_FAIL_IN,
	input wire logic ENGINE_DONE,
	output logic [7:0] DIAG_BITS
);
	import gcid_pkg::*;

	function automatic logic [15:0] read_word(input logic [6:0] a, input logic [15:0] s1, input logic [15:0] s2,
			input logic [15:0] s3, input logic [31:0] fc);
		logic [6:0] w;
		w = {a[6:1], 1'b0};
		case (w)
			ADDR_FW_REV: read_word = FW_REV_VAL;
			ADDR_MONTH_DAY: read_word = MONTH_DAY_VAL;
			ADDR_YEAR: read_word = YEAR_VAL;
			ADDR_PRODUCT: read_word = PRODUCT_CODE_VAL;
			ADDR_SERIAL: read_word = SERIAL_VAL;
			ADDR_SCRATCH1: read_word = s1;
			ADDR_SCRATCH2: read_word = s2;
			ADDR_SCRATCH3: read_word = s3;
			ADDR_FLASH_LO: read_word = fc[15:0];
			ADDR_FLASH_HI: read_word = fc[31:16];
			default: read_word = 16'h0000;
		endcase
	endfunction

	typedef struct packed {
		logic [2:0] sclk_s;
		logic [2:0] cs_s;
		logic [2:0] din_s;
		logic sclk_q;
		logic [3:0] bitcnt;
		logic [15:0] shift;
		logic [15:0] tx;
		logic [6:0] rd_addr;
		logic rd_pend;
		logic [7:0] cmd_lo;
		logic [15:0] scr1;
		logic [15:0] scr2;
		logic [15:0] scr3;
		logic [31:0] flash_cnt;
		logic [7:0] diag;
		logic [7:0] active;
		gcid_state_t st;
		logic [15:0] timer;
		logic [8:0] pulses;
		logic dr_q;
	} gcid_regs_t;

	gcid_regs_t q_r;
	gcid_regs_t q_nxt;
	logic sclk_lvl;
	logic cs_lvl;
	logic din_lvl;
	logic rise;
	logic fall;
	logic busy;
	logic [15:0] frame;

	// ----------------------------------------
	// Sampled pin levels: second and third stages must agree for SCLK and CS_N; DIN uses the second stage alone
	// ----------------------------------------
	assign sclk_lvl = (q_r.sclk_s[2] == q_r.sclk_s[1]) ? q_r.sclk_s[1] : q_r.sclk_q;
	assign cs_lvl = q_r.cs_s[2] & q_r.cs_s[1] ? 1'b1 : (~q_r.cs_s[2] & ~q_r.cs_s[1] ? 1'b0 : 1'b1);
	assign din_lvl = q_r.din_s[1];
	assign rise = sclk_lvl & ~q_r.sclk_q;
	assign fall = ~sclk_lvl & q_r.sclk_q;
	assign busy = (q_r.st != GCID_IDLE);
	assign frame = {q_r.shift[14:0], din_lvl};

	// ----------------------------------------
	// Next-state logic
	// ----------------------------------------
	always_comb begin
		q_nxt = q_r;
		q_nxt.sclk_s = {q_r.sclk_s[1:0], SCLK};
		q_nxt.cs_s = {q_r.cs_s[1:0], CS_N};
		q_nxt.din_s = {q_r.din_s[1:0], DIN};
		q_nxt.sclk_q = sclk_lvl;
		q_nxt.dr_q = DATA_READY_IN;
		q_nxt.pulses = '0;
		// Reply word is fetched one cycle after a read frame closes, ready before the next frame
		if (q_r.rd_pend) begin
			q_nxt.tx = read_word(q_r.rd_addr, q_r.scr1, q_r.scr2, q_r.scr3, q_r.flash_cnt);
			q_nxt.rd_pend = 1'b0;
		end
		// Serial port: ignored entirely while a command runs
		if (cs_lvl || busy) begin
			q_nxt.bitcnt = '0;
		end else if (rise) begin
			q_nxt.shift = frame;
			q_nxt.bitcnt = q_r.bitcnt + 4'h1;
			if (q_r.bitcnt == 4'(FRAME_BITS - 1)) begin
				// Full frame: flag, address, data byte
				if (frame[FRAME_WR_BIT]) begin
					case (frame[14:8])
						ADDR_CMD_LO: q_nxt.cmd_lo = frame[7:0];
						ADDR_CMD_HI: q_nxt.active = q_r.cmd_lo;
						ADDR_SCRATCH1: q_nxt.scr1[7:0] = frame[7:0];
						ADDR_SCRATCH1 + 7'h01: q_nxt.scr1[15:8] = frame[7:0];
						ADDR_SCRATCH2: q_nxt.scr2[7:0] = frame[7:0];
						ADDR_SCRATCH2 + 7'h01: q_nxt.scr2[15:8] = frame[7:0];
						ADDR_SCRATCH3: q_nxt.scr3[7:0] = frame[7:0];
						ADDR_SCRATCH3 + 7'h01: q_nxt.scr3[15:8] = frame[7:0];
						default: q_nxt.cmd_lo = q_r.cmd_lo;
					endcase
				end else begin
					q_nxt.rd_addr = frame[14:8];
					q_nxt.rd_pend = 1'b1;
				end
			end
		end else if (fall && q_r.bitcnt != 4'h0) begin
			// The first fall of a frame must not shift, or the top reply bit is lost
			q_nxt.tx = {q_r.tx[14:0], 1'b0};
		end
		// Command sequencer
		case (q_r.st)
			GCID_IDLE: begin
				if (q_r.active != 8'h00) begin
					q_nxt.timer = CMD_CYCLES;
					q_nxt.pulses[0] = q_r.active[CMD_SOFT_RESET];
					q_nxt.pulses[1] = q_r.active[CMD_FACTORY];
					q_nxt.pulses[2] = q_r.active[CMD_FACTORY];
					q_nxt.pulses[3] = q_r.active[CMD_BIAS_UPD];
					q_nxt.pulses[4] = q_r.active[CMD_BACKUP];
					q_nxt.pulses[5] = q_r.active[CMD_SELFTEST];
					q_nxt.pulses[6] = q_r.active[CMD_FLASHTEST];
					q_nxt.st = q_r.active[CMD_SELFTEST] ? GCID_STIM_OFF : GCID_RUN;
					if (q_r.active[CMD_BACKUP]) begin
						q_nxt.flash_cnt = q_r.flash_cnt + 32'h1;
					end
					if (q_r.active[CMD_SOFT_RESET]) begin
						q_nxt.scr1 = SCRATCH_RST;
						q_nxt.scr2 = SCRATCH_RST;
						q_nxt.scr3 = SCRATCH_RST;
					end
				end
			end
			GCID_STIM_OFF: begin
				// Baseline measure, then stimulus on
				if (MEASURE_DONE) begin
					q_nxt.st = GCID_STIM_ON;
					q_nxt.pulses[5] = 1'b1;
				end
			end
			GCID_STIM_ON: begin
				if (MEASURE_DONE) begin
					q_nxt.st = GCID_IDLE;
					q_nxt.active = '0;
					q_nxt.diag[DIAG_SELFTEST_FAIL] = SELFTEST_FAIL_IN;
				end
			end
			GCID_RUN: begin
				if (q_r.timer != 16'h0000) begin
					q_nxt.timer = q_r.timer - 16'h0001;
				end
				if (ENGINE_DONE || q_r.timer == 16'h0000) begin
					q_nxt.st = GCID_IDLE;
					q_nxt.active = '0;
					if (q_r.active[CMD_FLASHTEST] && CRC_MISMATCH_IN) begin
						q_nxt.diag[DIAG_FLASH_FAIL] = 1'b1;
					end
					if (q_r.active[CMD_BACKUP]) begin
						q_nxt.diag[DIAG_BACKUP_FAIL] = BACKUP_FAIL_IN;
					end
				end
			end
			default: q_nxt.st = GCID_IDLE;
		endcase
	end

	// ----------------------------------------
	// State register
	// ----------------------------------------
	always_ff @(posedge SYS_CLK) begin
		if (SRST) begin
			q_r <= '0;
			q_r.cs_s <= 3'h7;
			q_r.sclk_s <= 3'h7; // Serial clock idles high, so no false edge after reset
			q_r.sclk_q <= 1'b1;
			q_r.st <= GCID_IDLE;
		end else begin
			q_r <= q_nxt;
		end
	end

	// Outputs; ready pulses are gated while busy so none leak mid-command
	assign DOUT = q_r.tx[15];
	assign DATA_READY_OUT = q_r.dr_q & ~busy;
	assign DATA_HALT = busy;
	assign SENSOR_RESTART = q_r.pulses[0];
	assign FACTORY_RESTORE = q_r.pulses[1];
	assign BIAS_ZERO = q_r.pulses[2];
	assign BIAS_APPLY = q_r.pulses[3];
	assign FLASH_BACKUP = q_r.pulses[4];
	assign MEASURE_STROBE = q_r.pulses[5] | q_r.pulses[6];
	assign STIMULUS_ON = (q_r.st == GCID_STIM_ON);
	assign DIAG_BITS = q_r.diag;
endmodule
`default_nettype wire

// [sim/gcid_props.sv]
// Pin-level checks of the command block
`timescale 1ns/1ps
`default_nettype none
module gcid_props (
	input wire logic SYS_CLK,
	input wire logic SRST,
	input wire logic DATA_READY_IN,
	input wire logic DATA_READY_OUT,
	input wire logic DATA_HALT,
	input wire logic FACTORY_RESTORE,
	input wire logic BIAS_ZERO,
	input wire logic BIAS_APPLY,
	input wire logic FLASH_BACKUP,
	input wire logic STIMULUS_ON,
	input wire logic MEASURE_STROBE,
	input wire logic [7:0] DIAG_BITS
);
	default clocking cb @(posedge SYS_CLK);
	endclocking
	default disable iff (SRST);
	// Idle long enough for the gated ready copy to settle
	sequence idle3;
		!DATA_HALT [*3];
	endsequence
	// A backup start pulse is not repeated in the next eight cycles
	sequence lone_pulse;
		##1 !FLASH_BACKUP [*8];
	endsequence
	ready_gated_a: assert property (DATA_HALT && $past(DATA_HALT) |-> !DATA_READY_OUT)
		else $error("ready while busy");
	ready_copy_a: assert property (idle3 |-> DATA_READY_OUT == $past(DATA_READY_IN))
		else $error("ready not copied");
	start_halt_a: assert property (FACTORY_RESTORE || BIAS_APPLY || FLASH_BACKUP |-> ##[0:3] DATA_HALT)
		else $error("start without halt");
	restore_zero_a: assert property (FACTORY_RESTORE |-> BIAS_ZERO)
		else $error("restore kept offsets");
	stim_start_a: assert property ($rose(STIMULUS_ON) |-> MEASURE_STROBE)
		else $error("stimulus without measure");
	stim_busy_a: assert property (STIMULUS_ON |-> DATA_HALT)
		else $error("stimulus while idle");
	backup_once_a: assert property (FLASH_BACKUP |-> lone_pulse)
		else $error("backup pulse repeated");
	diag_quiet_a: assert property (idle3 |-> $stable(DIAG_BITS))
		else $error("status moved while idle");
endmodule
bind gcid_top gcid_props chk_u (.SYS_CLK, .SRST, .DATA_READY_IN, .DATA_READY_OUT, .DATA_HALT, .FACTORY_RESTORE,
	.BIAS_ZERO, .BIAS_APPLY, .FLASH_BACKUP, .STIMULUS_ON, .MEASURE_STROBE, .DIAG_BITS);
`default_nettype wire

// [sim/gcid_host.sv]
// Serial host model: 16-bit frames, MSB first, clock idles high
`timescale 1ns/1ps
`default_nettype none
module gcid_host (
	output logic sclk,
	output logic cs_n,
	output logic din,
	input wire logic dout
);
	initial begin
		sclk = 1'b1;
		cs_n = 1'b1;
		din = 1'b0;
	end
	// One frame; reply bits are taken at each rising edge
	task automatic frame(input logic [15:0] w, output logic [15:0] q);
		cs_n = 1'b0;
		#80;
		for (int i = 15; i >= 0; i--) begin
			sclk = 1'b0;
			din = w[i]; // Flag, address, data
			#80 sclk = 1'b1;
			q[i] = dout;
			#80;
		end
		cs_n = 1'b1;
		din = ~din; // Released line must not keep its last bit
		#480;
	endtask
endmodule
`default_nettype wire

// [sim/gcid_bench.sv]
// Bench: host frames, sensor responder and checks
`timescale 1ns/1ps
`default_nettype none
module gcid_bench;
	import gcid_pkg::*;
	logic clk = 1'b0;
	logic srst = 1'b1;
	logic dri = 1'b0;
	logic md = 1'b0;
	logic ed = 1'b0;
	logic stf = 1'b1;
	logic crc = 1'b1;
	logic bkf = 1'b0;
	logic sclk, cs_n, din, dout, dro, halt, rs, fr, bz, ba, fb, stim, ms;
	logic [7:0] diag;
	logic [7:0] seen = 8'h00;
	logic [15:0] r;
	int hc = 0;
	int miscompares = 0;
	int n_checks = 0;
	// Command byte, start pulses and status expected
	logic [7:0] c_t [6] = '{8'h00, 8'h08, 8'h04, 8'h10, 8'h02, 8'h01};
	logic [7:0] s_t [6] = '{8'h00, 8'h04, 8'h03, 8'h01, 8'h30, 8'h08};
	logic [7:0] d_t [6] = '{8'h00, 8'h00, 8'h20, 8'h60, 8'h60, 8'h60};
	always #5 clk = ~clk;
	gcid_top dut_u (.SYS_CLK(clk), .SRST(srst), .SCLK(sclk), .CS_N(cs_n), .DIN(din), .DOUT(dout),
		.DATA_READY_IN(dri), .DATA_READY_OUT(dro), .DATA_HALT(halt), .SENSOR_RESTART(rs),
		.FACTORY_RESTORE(fr), .BIAS_ZERO(bz), .BIAS_APPLY(ba), .FLASH_BACKUP(fb), .STIMULUS_ON(stim),
		.MEASURE_STROBE(ms), .MEASURE_DONE(md), .SELFTEST_FAIL_IN(stf), .CRC_MISMATCH_IN(crc),
		.BACKUP_FAIL_IN(bkf), .ENGINE_DONE(ed), .DIAG_BITS(diag));
	gcid_host host_u (.sclk(sclk), .cs_n(cs_n), .din(din), .dout(dout));
	// Sensor side is slow on purpose, so a frame fits inside every command
	always @(negedge clk) begin
		hc <= halt ? hc + 1 : 0;
		md <= (hc == 400 || hc == 500);
		ed <= (hc == 600);
		dri <= !srst && !dri;
	end
	always @(posedge clk) seen <= seen | {1'b0, rs, fr, bz, ba, fb, stim, ms};
	task automatic chk(input string n, input logic [15:0] g, input logic [15:0] e);
		n_checks++;
		if (g !== e) begin
			miscompares++;
			$display("[ERR] %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		host_u.frame({1'b1, a, d}, r);
	endtask
	// The reply comes in the frame after the request
	task automatic rd(input logic [6:0] a, input logic [15:0] e, input string n);
		host_u.frame({1'b0, a, 8'h00}, r);
		host_u.frame({1'b0, ADDR_PRODUCT, 8'h00}, r);
		chk(n, r, e);
	endtask
	task automatic cmd(input logic [7:0] c, input logic [7:0] s, input logic [7:0] d);
		seen = 8'h00;
		wr(ADDR_CMD_LO, c);
		wr(ADDR_CMD_HI, 8'h00);
		if (c != 8'h00) begin
			chk("busy", {15'h0, halt}, 16'h0001); // Halt
			wr(ADDR_SCRATCH3, 8'hFF);
		end
		for (int i = 0; i < 2000 && halt; i++) @(negedge clk);
		repeat (2) @(negedge clk);
		chk("pulses", {8'h00, seen}, {8'h00, s}); // Starts
		if (!c[7]) chk("diag", {8'h00, diag & 8'h64}, {8'h00, d}); // Status
	endtask
	task automatic results();
		$display("checks %0d mismatches %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	initial begin
		repeat (16) @(negedge clk);
		srst = 1'b0;
		repeat (4) @(negedge clk);
		rd(ADDR_FW_REV, FW_REV_VAL, "fw"); // BCD
		rd(ADDR_MONTH_DAY, MONTH_DAY_VAL, "md"); // Date
		rd(ADDR_YEAR, YEAR_VAL, "yr"); // Year
		wr(ADDR_PRODUCT, 8'h00);
		wr(ADDR_SERIAL + 7'h1, 8'h00);
		rd(ADDR_PRODUCT, PRODUCT_CODE_VAL, "prod"); // Fixed
		rd(ADDR_SERIAL, SERIAL_VAL, "ser"); // Fixed
		$display("ids done");
		wr(ADDR_SCRATCH1, 8'hCD);
		wr(ADDR_SCRATCH1 + 7'h1, 8'hAB);
		wr(ADDR_SCRATCH2 + 7'h1, 8'h12);
		rd(ADDR_SCRATCH1, 16'hABCD, "scr1"); // Bytes
		rd(ADDR_SCRATCH2, {8'h12, SCRATCH_RST[7:0]}, "scr2"); // Bytes
		$display("scratch done");
		foreach (c_t[i]) cmd(c_t[i], s_t[i], d_t[i]); // Table
		bkf = 1'b1;
		cmd(8'h08, 8'h04, 8'h64); // Failed backup
		rd(ADDR_FLASH_LO, FLASH_CNT_RST[15:0] + 16'h2, "fl_lo"); // Count
		rd(ADDR_FLASH_HI, FLASH_CNT_RST[31:16], "fl_hi"); // Count
		rd(ADDR_SCRATCH3, SCRATCH_RST, "scr3"); // Refused
		$display("commands done");
		cmd(8'h80, 8'h40, 8'h00); // Restart
		rd(ADDR_SCRATCH1, SCRATCH_RST, "scr1_rst"); // Cleared
		$display("soft reset done");
		results();
	end
	// Watchdog: the tests need well under this span
	initial begin
		#800000;
		miscompares++;
		results();
	end
endmodule
`default_nettype wire
